// ### literal_move_return_exec_pkg.sv
package literal_move_return_exec_pkg;

    // Clock and return timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int RETURN_CYCLES = 2;

    // Instruction word layout
    localparam int INSTR_W = 14;
    localparam int PC_W    = 15;
    localparam int PTR_W   = 16;

    // Opcode patterns; '?' marks operand bits
    localparam logic [13:0] OP_IDLE   = 14'b00_0000_0000_0000;
    localparam logic [13:0] OP_RESET  = 14'b00_0000_0000_0001;
    localparam logic [13:0] OP_RETFI  = 14'b00_0000_0000_1001;
    localparam logic [13:0] OP_WIMODE = 14'b00_0000_0001_1???;
    localparam logic [13:0] OP_LBANK  = 14'b00_0000_001?_????;
    localparam logic [13:0] OP_WFILE  = 14'b00_0000_1???_????;
    localparam logic [13:0] OP_LWORK  = 14'b11_0000_????_????;
    localparam logic [13:0] OP_LPAGE  = 14'b11_0001_1???_????;
    localparam logic [13:0] OP_WIREL  = 14'b11_1111_1???_????;

    // Operand fields
    localparam int PTR_SEL_BIT = 2;
    localparam int REL_SEL_BIT = 6;
    localparam int MODE_LSB    = 0;
    localparam int OFFS_MSB    = 5;

    // Indirect mode field encodings
    localparam logic [1:0] MODE_PREINC  = 2'h0;
    localparam logic [1:0] MODE_PREDEC  = 2'h1;
    localparam logic [1:0] MODE_POSTINC = 2'h2;
    localparam logic [1:0] MODE_POSTDEC = 2'h3;

    // File addresses of the two indirect access ports
    localparam logic [6:0] IND0_ADDR = 7'h00;
    localparam logic [6:0] IND1_ADDR = 7'h01;

    // Register byte offsets
    localparam logic [7:0] ADDR_WORK     = 8'h00;
    localparam logic [7:0] ADDR_BANK     = 8'h04;
    localparam logic [7:0] ADDR_PAGE     = 8'h08;
    localparam logic [7:0] ADDR_PTR0     = 8'h0c;
    localparam logic [7:0] ADDR_PTR1     = 8'h10;
    localparam logic [7:0] ADDR_INT_CTRL = 8'h14;
    localparam logic [7:0] ADDR_PWR_CTRL = 8'h18;
    localparam logic [7:0] ADDR_PC       = 8'h1c;
    localparam logic [7:0] ADDR_STATUS   = 8'h20;

    // Field positions and reset values
    localparam int          INT_EN_BIT     = 7;
    localparam int          RST_FLAG_BIT   = 2;
    localparam logic        RST_FLAG_RESET = 1'b1;
    localparam logic [7:0]  INT_CTRL_RST   = 8'h00;
    localparam logic [2:0]  STATUS_RST     = 3'h0;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

endpackage : literal_move_return_exec_pkg

// ### literal_move_return_exec.sv
`timescale 1ns/1ps
// How it works
// - Bank literal instruction loads five-bit operand into bank select, flags untouched.
// - Page literal instruction loads seven-bit operand into page latch, flags untouched.
// - Work literal instruction loads eight-bit operand into work register in one cycle.
// - Store-to-file writes work register to seven-bit file address in one cycle.
// - Indirect store writes work to pointer plus one, minus one, the pointer itself (post modes), or pointer plus signed offset.
// - Mode field: 00 preinc, 01 predec, 10 postinc, 11 postdec.
// - Afterwards pointer is old plus one, minus one, or unchanged for offset.
// - Accessing the indirect port writes the address held in its pointer instead.
// - Pointers are sixteen bits and wrap modulo the full range.
// - Indirect store and its pointer update change no status flag.
// - Software reset loads the core registers with their hardware reset values, leaves the bus side alone, and clears the reset-instruction flag.
// - Return from interrupt pops stack into PC, two cycles, one word.
// - Return from interrupt sets global interrupt enable, bit seven of control.
module literal_move_return_exec
    import literal_move_return_exec_pkg::*;
(
    input  wire logic                SYS_CLK,
    input  wire logic                RESETN,
    input  wire logic [INSTR_W-1:0]  INSTR,
    input  wire logic                INSTR_VALID,
    output logic                     INSTR_READY,
    input  wire logic [PC_W-1:0]     TOP_OF_STACK,
    output logic                     STACK_POP,
    output logic [PC_W-1:0]          PC,
    output logic                     CORE_RESET,
    output logic                     DATA_WE,
    output logic [PTR_W-1:0]         DATA_ADDR,
    output logic [7:0]               DATA_WDATA,
    input  wire logic [7:0]          AWADDR,
    input  wire logic                AWVALID,
    output logic                     AWREADY,
    input  wire logic [31:0]         WDATA,
    input  wire logic [3:0]          WSTRB,
    input  wire logic                WVALID,
    output logic                     WREADY,
    output logic [1:0]               BRESP,
    output logic                     BVALID,
    input  wire logic                BREADY,
    input  wire logic [7:0]          ARADDR,
    input  wire logic                ARVALID,
    output logic                     ARREADY,
    output logic [31:0]              RDATA,
    output logic [1:0]               RRESP,
    output logic                     RVALID,
    input  wire logic                RREADY
);

    typedef struct packed {
        logic [7:0]       work;
        logic [4:0]       bank;
        logic [6:0]       page;
        logic [PTR_W-1:0] ptr0;
        logic [PTR_W-1:0] ptr1;
        logic [7:0]       int_ctrl;
        logic             rst_flag;
        logic [2:0]       status;
        logic [PC_W-1:0]  pc;
        logic             ready;
        logic             pop;
        logic             core_rst;
        logic             we;
        logic [PTR_W-1:0] waddr;
        logic [7:0]       wdata;
        logic             have_aw;
        logic [7:0]       aw_addr;
        logic             have_w;
        logic [31:0]      w_data;
        logic [3:0]       w_strb;
        logic             awready;
        logic             wready;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             arready;
        logic             rvalid;
        logic [31:0]      rdata;
        logic [1:0]       rresp;
    } state_s;

    state_s s;
    state_s next_s;

    // Byte-lane merge of a bus write into an old value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // Register read decode; unmapped addresses are flagged
    function automatic logic [32:0] read_reg(input state_s st, input logic [7:0] a);
        logic [32:0] r;
        r = {1'b0, 32'h0000_0000};
        case (a)
            ADDR_WORK:   r[7:0] = st.work;
            ADDR_BANK:   r[4:0] = st.bank;
            ADDR_PAGE:   r[6:0] = st.page;
            ADDR_PTR0:   r[15:0] = st.ptr0;
            ADDR_PTR1:   r[15:0] = st.ptr1;
            ADDR_INT_CTRL: r[7:0] = st.int_ctrl;
            ADDR_PWR_CTRL: r[RST_FLAG_BIT] = st.rst_flag;
            ADDR_PC:     r[PC_W-1:0] = st.pc;
            ADDR_STATUS: r[2:0] = st.status;
            default:     r[32] = 1'b1;
        endcase
        return r;
    endfunction : read_reg

    // Core registers to their reset values, bus side left alone
    function automatic state_s core_reset(input state_s st);
        state_s r;
        r = st;
        r.work     = 8'h00;
        r.bank     = 5'h00;
        r.page     = 7'h00;
        r.ptr0     = 16'h0000;
        r.ptr1     = 16'h0000;
        r.int_ctrl = INT_CTRL_RST;
        r.status   = STATUS_RST;
        r.pc       = 15'h0000;
        r.ready    = 1'b1;
        r.pop      = 1'b0;
        r.we       = 1'b0;
        r.waddr    = 16'h0000;
        r.wdata    = 8'h00;
        r.core_rst = 1'b0;
        return r;
    endfunction : core_reset

    logic             go;
    logic             sel;
    logic [1:0]       mode;
    logic [PTR_W-1:0] ptr_old;
    logic [PTR_W-1:0] ptr_new;
    logic [PTR_W-1:0] eff;
    logic [PTR_W-1:0] offs;
    logic [31:0]      m;
    logic [32:0]      rd;

    // Next-state logic: bus slave first, then instruction execution
    always_comb begin
        next_s  = s;
        sel     = 1'b0;
        mode    = MODE_PREINC;
        ptr_old = 16'h0000;
        ptr_new = 16'h0000;
        eff     = 16'h0000;
        offs    = 16'h0000;
        m       = 32'h0000_0000;
        rd      = 33'h0_0000_0000;
        go      = INSTR_VALID && s.ready;
        next_s.pop      = 1'b0;
        next_s.we       = 1'b0;
        next_s.core_rst = 1'b0;
        next_s.ready    = 1'b1;

        // Write channels may arrive in either order
        if (AWVALID && s.awready) begin
            next_s.have_aw = 1'b1;
            next_s.aw_addr = AWADDR;
        end
        if (WVALID && s.wready) begin
            next_s.have_w = 1'b1;
            next_s.w_data = WDATA;
            next_s.w_strb = WSTRB;
        end
        if (s.bvalid && BREADY) begin
            next_s.bvalid = 1'b0;
        end
        if (s.have_aw && s.have_w && !s.bvalid) begin
            next_s.have_aw = 1'b0;
            next_s.have_w  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = RESP_OKAY;
            case (s.aw_addr)
                ADDR_WORK: begin
                    m = merge({24'h0, s.work}, s.w_data, s.w_strb);
                    next_s.work = m[7:0];
                end
                ADDR_BANK: begin
                    m = merge({27'h0, s.bank}, s.w_data, s.w_strb);
                    next_s.bank = m[4:0];
                end
                ADDR_PAGE: begin
                    m = merge({25'h0, s.page}, s.w_data, s.w_strb);
                    next_s.page = m[6:0];
                end
                ADDR_PTR0: begin
                    m = merge({16'h0, s.ptr0}, s.w_data, s.w_strb);
                    next_s.ptr0 = m[15:0];
                end
                ADDR_PTR1: begin
                    m = merge({16'h0, s.ptr1}, s.w_data, s.w_strb);
                    next_s.ptr1 = m[15:0];
                end
                ADDR_INT_CTRL: begin
                    m = merge({24'h0, s.int_ctrl}, s.w_data, s.w_strb);
                    next_s.int_ctrl = m[7:0];
                end
                ADDR_PWR_CTRL: begin
                    m = merge({29'h0, s.rst_flag, 2'h0}, s.w_data, s.w_strb);
                    next_s.rst_flag = m[RST_FLAG_BIT];
                end
                ADDR_STATUS: begin
                    m = merge({29'h0, s.status}, s.w_data, s.w_strb);
                    next_s.status = m[2:0];
                end
                ADDR_PC: next_s.bresp = RESP_OKAY;  // Read only, write ignored
                default: next_s.bresp = RESP_SLVERR;
            endcase
        end
        next_s.awready = !next_s.have_aw && !next_s.bvalid;
        next_s.wready  = !next_s.have_w && !next_s.bvalid;

        // Read channel: one outstanding read
        if (s.rvalid && RREADY) begin
            next_s.rvalid = 1'b0;
        end
        if (ARVALID && s.arready) begin
            rd            = read_reg(s, ARADDR);
            next_s.rdata  = rd[31:0];
            next_s.rresp  = rd[32] ? RESP_SLVERR : RESP_OKAY;
            next_s.rvalid = 1'b1;
        end
        next_s.arready = !next_s.rvalid;

        // Instruction execution; status is written here only by the software reset
        if (go) begin
            next_s.pc = s.pc + 15'h0001;
            casez (INSTR)
                OP_IDLE: begin
                    next_s.pc = s.pc + 15'h0001;
                end
                OP_RESET: begin
                    next_s          = core_reset(next_s);
                    next_s.rst_flag = 1'b0;
                    next_s.core_rst = 1'b1;
                end
                OP_RETFI: begin
                    next_s.pc                 = TOP_OF_STACK;
                    next_s.pop                = 1'b1;
                    next_s.ready              = 1'b0;
                    next_s.int_ctrl[INT_EN_BIT] = 1'b1;
                end
                OP_WIMODE, OP_WIREL: begin
                    if (INSTR[13]) begin
                        sel = INSTR[REL_SEL_BIT];
                    end else begin
                        sel = INSTR[PTR_SEL_BIT];
                    end
                    mode    = INSTR[MODE_LSB +: 2];
                    ptr_old = sel ? s.ptr1 : s.ptr0;
                    offs    = {{10{INSTR[OFFS_MSB]}}, INSTR[OFFS_MSB:0]};
                    if (INSTR[13]) begin
                        eff     = ptr_old + offs;
                        ptr_new = ptr_old;
                    end else begin
                        case (mode)
                            MODE_PREINC: begin
                                ptr_new = ptr_old + 16'h0001;
                                eff     = ptr_new;
                            end
                            MODE_PREDEC: begin
                                ptr_new = ptr_old - 16'h0001;
                                eff     = ptr_new;
                            end
                            MODE_POSTINC: begin
                                ptr_new = ptr_old + 16'h0001;
                                eff     = ptr_old;
                            end
                            default: begin
                                ptr_new = ptr_old - 16'h0001;
                                eff     = ptr_old;
                            end
                        endcase
                    end
                    if (sel) begin
                        next_s.ptr1 = ptr_new;
                    end else begin
                        next_s.ptr0 = ptr_new;
                    end
                    next_s.we    = 1'b1;
                    next_s.waddr = eff;
                    next_s.wdata = s.work;
                end
                OP_LBANK: begin
                    next_s.bank = INSTR[4:0];
                end
                OP_WFILE: begin
                    next_s.we    = 1'b1;
                    next_s.wdata = s.work;
                    if (INSTR[6:0] == IND0_ADDR) begin
                        next_s.waddr = s.ptr0;
                    end else if (INSTR[6:0] == IND1_ADDR) begin
                        next_s.waddr = s.ptr1;
                    end else begin
                        next_s.waddr = {4'h0, s.bank, INSTR[6:0]};
                    end
                end
                OP_LWORK: begin
                    next_s.work = INSTR[7:0];
                end
                OP_LPAGE: begin
                    next_s.page = INSTR[6:0];
                end
                default: begin
                    next_s.pc = s.pc + 15'h0001;               // Unhandled words only advance
                end
            endcase
        end
    end

    // State register with synchronous reset
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            s         <= core_reset('0);
            s.rst_flag <= RST_FLAG_RESET;
            s.awready <= 1'b1;
            s.wready  <= 1'b1;
            s.arready <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign INSTR_READY = s.ready;
    assign STACK_POP   = s.pop;
    assign PC          = s.pc;
    assign CORE_RESET  = s.core_rst;
    assign DATA_WE     = s.we;
    assign DATA_ADDR   = s.waddr;
    assign DATA_WDATA  = s.wdata;
    assign AWREADY     = s.awready;
    assign WREADY      = s.wready;
    assign BRESP       = s.bresp;
    assign BVALID      = s.bvalid;
    assign ARREADY     = s.arready;
    assign RDATA       = s.rdata;
    assign RRESP       = s.rresp;
    assign RVALID      = s.rvalid;

endmodule : literal_move_return_exec

// ### literal_move_return_exec_asserts.sv
`timescale 1ns/1ps
module literal_move_return_exec_asserts
    import literal_move_return_exec_pkg::*;
(
    input logic               SYS_CLK,
    input logic               RESETN,
    input logic [INSTR_W-1:0] INSTR,
    input logic               INSTR_VALID,
    input logic               INSTR_READY,
    input logic [PC_W-1:0]    TOP_OF_STACK,
    input logic               STACK_POP,
    input logic [PC_W-1:0]    PC,
    input logic               CORE_RESET,
    input logic               DATA_WE,
    input logic [PTR_W-1:0]   DATA_ADDR
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);

    // Accepted word and its class
    logic take;
    logic lit;
    logic store;
    assign take = INSTR_VALID && INSTR_READY;
    assign lit = INSTR[13:8] == 6'h30 || INSTR[13:7] == 7'h63 || INSTR[13:5] == 9'h001;
    assign store = INSTR[13:7] == 7'h01 || INSTR[13:3] == 11'h003 || INSTR[13:7] == 7'h7f;

    // Return steps: pop with the port stalled, then free again
    sequence ret_taken;
        take && INSTR == 14'h0009;
    endsequence
    sequence ret_done;
        STACK_POP && !INSTR_READY && PC == $past(TOP_OF_STACK) ##1 INSTR_READY;
    endsequence

    a_return_steps: assert property (ret_taken |=> ret_done) else $error("return sequence wrong");
    a_pop_cause: assert property (STACK_POP |-> $past(take && INSTR == 14'h0009)) else $error("stray pop");
    a_stall_refuse: assert property (INSTR_VALID && !INSTR_READY |=> !DATA_WE && !STACK_POP) else $error("stall taken");
    a_soft_reset: assert property (take && INSTR == 14'h0001 |=> CORE_RESET && PC == 15'h0) else $error("reset wrong");
    a_nop_advance: assert property (take && INSTR == 14'h0000 |=> PC == $past(PC) + 15'h1 && !DATA_WE) else $error("nop wrong");
    a_literal_quiet: assert property (take && lit |=> !DATA_WE && !STACK_POP && !CORE_RESET) else $error("literal side effect");
    a_file_address: assert property (take && INSTR[13:7] == 7'h01 && INSTR[6:1] != 6'h0 |=> DATA_WE && DATA_ADDR[15:12] == 4'h0 && DATA_ADDR[6:0] == $past(INSTR[6:0])) else $error("file address wrong");
    a_write_cause: assert property (DATA_WE |-> $past(take && store)) else $error("stray write");
endmodule : literal_move_return_exec_asserts

bind literal_move_return_exec literal_move_return_exec_asserts chk (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .INSTR(INSTR),
    .INSTR_VALID(INSTR_VALID), .INSTR_READY(INSTR_READY), .TOP_OF_STACK(TOP_OF_STACK), .STACK_POP(STACK_POP), .PC(PC),
    .CORE_RESET(CORE_RESET), .DATA_WE(DATA_WE), .DATA_ADDR(DATA_ADDR));

// ### literal_move_return_exec_tb.sv
`timescale 1ns/1ps
module literal_move_return_exec_tb import literal_move_return_exec_pkg::*; ;
    logic        clk = 0, rst_n = 0, ivalid = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [13:0] instr = '0;
    logic [14:0] stack_top = '0;
    logic [7:0]  awaddr = '0, araddr = '0, dwdata;
    logic [31:0] wdata = '0, rd, rdata, seed = 32'h3084;
    logic [1:0]  rr, br, bresp, rresp;
    logic [14:0] pc;
    logic [15:0] daddr;
    logic        ready, pop, cres, we, awready, wready, bvalid, arready, rvalid;
    int          miscompares = 0, compares = 0, cycles = 0, pops = 0;

    literal_move_return_exec DUT (.SYS_CLK(clk), .RESETN(rst_n), .INSTR(instr), .INSTR_VALID(ivalid),
        .INSTR_READY(ready), .TOP_OF_STACK(stack_top), .STACK_POP(pop), .PC(pc), .CORE_RESET(cres), .DATA_WE(we),
        .DATA_ADDR(daddr), .DATA_WDATA(dwdata), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
        .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
        .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));

    // Clock, pop counter and hang limit
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (pop === 1'b1) pops++;
        if (cycles == 20000) begin
            miscompares++;
            complete_run();
        end
    end

    function automatic logic [31:0] next_rand();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction : next_rand

    // Expected {address, pointer after} of an indirect store
    function automatic logic [31:0] ind_exp(input logic [15:0] p, input logic [1:0] m);
        case (m)
            2'h0: return {p + 16'h1, p + 16'h1};
            2'h1: return {p - 16'h1, p - 16'h1};
            2'h2: return {p, p + 16'h1};
            default: return {p, p - 16'h1};
        endcase
    endfunction : ind_exp

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        logic aw_t, w_t, b_t;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        b_t = 1'b0;
        while (!b_t) begin
            @(negedge clk);
            aw_t = awvalid && awready;
            w_t = wvalid && wready;
            b_t = bvalid;
            br = bresp;
            @(posedge clk);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask : bus_write

    task automatic bus_read(input logic [7:0] a);
        logic ar_t, r_t;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        r_t = 1'b0;
        while (!r_t) begin
            @(negedge clk);
            ar_t = arvalid && arready;
            r_t = rvalid;
            rd = rdata;
            rr = rresp;
            @(posedge clk);
            if (ar_t) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask : bus_read

    // Offer one word until taken; more keeps the port busy for the next one
    task automatic run(input logic [13:0] i, input bit more);
        logic t;
        instr <= i;
        ivalid <= 1'b1;
        t = 1'b0;
        while (!t) begin
            @(negedge clk);
            t = ready;
            @(posedge clk);
        end
        if (!more) ivalid <= 1'b0;
    endtask : run

    task automatic complete_run();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run

    // Main sequence
    initial begin
        logic [31:0] r, e;
        logic [15:0] p;
        logic [6:0]  f;
        logic [4:0]  bk;
        logic        n;
        int          i;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 10; i++) begin
            bus_read(8'(i * 4));
            check(rd, i == 6 ? 32'h4 : 32'h0);
            check(32'(rr), i == 9 ? 32'(RESP_SLVERR) : 32'(RESP_OKAY));
        end
        $display("test reset_values done");
        bus_write(ADDR_STATUS, 32'h5);
        check(32'(br), 32'(RESP_OKAY));
        bus_write(8'h24, 32'h0);
        check(32'(br), 32'(RESP_SLVERR));
        for (i = 0; i < 16; i++) begin
            r = i == 0 ? 32'h0 : (i == 1 ? 32'hffffffff : next_rand());
            run(14'h3000 | 14'(r[7:0]), 1);
            run(14'h0020 | 14'(r[12:8]), 1);
            run(14'h3180 | 14'(r[22:16]), 0);
            bus_read(ADDR_WORK);
            check(rd, 32'(r[7:0]));
            bus_read(ADDR_BANK);
            check(rd, 32'(r[12:8]));
            bus_read(ADDR_PAGE);
            check(rd, 32'(r[22:16]));
            bk = r[12:8];
        end
        $display("test literal_loads done");
        for (i = 0; i < 16; i++) begin
            r = next_rand();
            n = i[2];
            p = i[3] ? r[15:0] : (i[0] ? 16'h0 : 16'hffff);
            bus_write(n ? ADDR_PTR1 : ADDR_PTR0, 32'(p));
            run(14'h3000 | 14'(r[23:16]), 1);
            run(14'h0018 | 14'({n, i[1:0]}), 0);
            e = ind_exp(p, i[1:0]);
            @(negedge clk);
            check(32'(we), 32'h1);
            check(32'(daddr), 32'(e[31:16]));
            check(32'(dwdata), 32'(r[23:16]));
            bus_read(n ? ADDR_PTR1 : ADDR_PTR0);
            check(rd, 32'(e[15:0]));
            run(14'h3f80 | 14'({n, r[29:24]}), 0);
            @(negedge clk);
            check(32'(daddr), 32'(16'(e[15:0] + {{10{r[29]}}, r[29:24]})));
            bus_read(n ? ADDR_PTR1 : ADDR_PTR0);
            check(rd, 32'(e[15:0]));
            f = i[3] ? (r[30:24] | 7'h2) : 7'(n);
            run(14'h0080 | 14'(f), 0);
            @(negedge clk);
            check(32'(daddr), i[3] ? {20'h0, bk, f} : 32'(e[15:0]));
            check(32'(dwdata), 32'(r[23:16]));
        end
        bus_read(ADDR_STATUS);
        check(rd, 32'h5);
        $display("test stores done");
        bus_read(ADDR_PC);
        p = rd[15:0];
        run(14'h0000, 0);
        bus_read(ADDR_PC);
        check(rd, 32'(p[14:0] + 15'h1));
        bus_write(ADDR_INT_CTRL, 32'h0);
        stack_top <= 15'(next_rand());
        run(14'h0009, 1);
        run(14'h0000, 0);
        bus_read(ADDR_INT_CTRL);
        check(rd, 32'h80);
        bus_read(ADDR_PC);
        check(rd, 32'(15'(stack_top + 15'h1)));
        check(32'(pops), 32'h1);
        $display("test return done");
        run(14'h303c, 1);
        run(14'h0001, 0);
        @(negedge clk);
        check(32'(cres), 32'h1);
        bus_read(ADDR_PWR_CTRL);
        check(rd, 32'h0);
        bus_read(ADDR_WORK);
        check(rd, 32'h0);
        $display("test soft_reset done");
        complete_run();
    end
endmodule : literal_move_return_exec_tb
